// file: rtl/uart_ir_pkg.sv
// constants, field layouts and state types for the uart with infrared endec
// How it works
// (RULE1) shared x16 tick, divide 2x16 to 65536x16
// (RULE2) five to eight data bits
// (RULE3) even, odd or no parity, no stick
// (RULE4) one or two stop bits only
// (RULE5) framing bits added on send, stripped on receive
// (RULE6) short low on input is no start
// (RULE7) send break on request, detect break received
// (RULE8) sixteen entry fifo each way
// (RULE9) fifo off means one entry holding register
// (RULE10) receive trigger fixed at eight entries
// (RULE11) error flags stored with each character
// (RULE12) stored errors raise no interrupt
// (RULE13) overrun flags at once, keeps stored data
// (RULE14) four separately maskable interrupt sources
// (RULE15) combined interrupt when any source unmasked
// (RULE16) cts, dcd, dsr inputs only
// (RULE17) infrared pins replace wired pins
// (RULE18) infrared mode: tx high, wired inputs ignored
// (RULE19) infrared mode is half duplex
// (RULE20) ten ms turnaround before receive
// (RULE21) low power tick divides by 2 to 511
// (RULE22) pulse 3/16 bit or three low power ticks
// (RULE23) x16 tick is one clock wide pulse
// (RULE24) start, data lsb first, parity, stop
// (RULE25) pulse valid if low one tick later
// (RULE26) encoder idles low, high pulse per zero
package uart_ir_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_DATA = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_LINE = 12'h008;
  localparam logic [11:0] OFF_BAUD = 12'h00c;
  localparam logic [11:0] OFF_CTRL = 12'h010;
  localparam logic [11:0] OFF_ILP = 12'h014;
  localparam logic [11:0] OFF_INT = 12'h018;
  // status bit positions
  localparam int ST_OVR = 0;
  localparam int ST_TXFULL = 1;
  localparam int ST_TXEMPTY = 2;
  localparam int ST_RXFULL = 3;
  localparam int ST_RXEMPTY = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_CTS = 6;
  localparam int ST_DCD = 7;
  localparam int ST_DSR = 8;
  // interrupt source positions
  localparam int INT_TX = 0;
  localparam int INT_RX = 1;
  localparam int INT_TO = 2;
  localparam int INT_MS = 3;
  localparam int INT_N = 4;
  // synchroniser lanes
  localparam int SY_RX = 0;
  localparam int SY_IR = 1;
  localparam int SY_CTS = 2;
  localparam int SY_DCD = 3;
  localparam int SY_DSR = 4;
  localparam int SYNC_W = 5;
  localparam logic [4:0] SYNC_RST = 5'h03;
  // fifo geometry and levels
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam logic [4:0] LVL_FULL = 5'h10;
  localparam logic [4:0] LVL_SINGLE = 5'h01;
  localparam logic [4:0] LVL_TRIG = 5'h08;
  // bit timing in x16 ticks
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [1:0] PULSE_LAST = 2'h2;
  localparam logic [2:0] WLEN_BASE = 3'h4;
  localparam logic [9:0] TIMEOUT_TICKS = 10'h200;
  // divider limits and reset values
  localparam logic [15:0] BAUD_MIN = 16'h0001;
  localparam logic [8:0] ILP_MIN = 9'h002;
  localparam logic [8:0] ILP_ONE = 9'h001;
  // infrared turnaround, time then cycles
  localparam int TURN_MS = 10;
  localparam int CLK_KHZ = 250000;
  localparam int TURN_CYCLES_DFLT = TURN_MS * CLK_KHZ;
  localparam int TURN_W = 22;

  typedef struct packed {
    logic brk;
    logic fifo_en;
    logic stop2;
    logic even;
    logic par_en;
    logic [1:0] wlen;
  } line_ctrl_s;

  typedef struct packed {
    logic [3:0] int_mask;
    logic ir_lp;
    logic ir_en;
    logic uart_en;
  } ctrl_s;

  typedef struct packed {
    logic brk_err;
    logic par_err;
    logic frm_err;
    logic [7:0] data;
  } rx_entry_s;

  localparam line_ctrl_s LINE_RST = 7'h03;
  localparam ctrl_s CTRL_RST = 7'h00;

  typedef enum logic [4:0] {
    T_IDLE = 5'b00001,
    T_START = 5'b00010,
    T_DATA = 5'b00100,
    T_PAR = 5'b01000,
    T_STOP = 5'b10000
  } tx_state_e;

  typedef enum logic [5:0] {
    R_IDLE = 6'b000001,
    R_START = 6'b000010,
    R_DATA = 6'b000100,
    R_PAR = 6'b001000,
    R_STOP = 6'b010000,
    R_BRK = 6'b100000
  } rx_state_e;
endpackage : uart_ir_pkg

// file: rtl/uart_with_ir_sir_endec.sv
// apb uart with fifos, baud generator and infrared pulse encoder/decoder
`timescale 1ns/1ps
module uart_with_ir_sir_endec import uart_ir_pkg::*; #(
  parameter int unsigned TURN_CYCLES = TURN_CYCLES_DFLT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wired serial
  input wire logic wired_serial_rx,
  output logic wired_serial_tx,
  // infrared transducer
  input wire logic ir_pulse_in,
  output logic ir_pulse_out_low,
  // modem status
  input wire logic clear_to_send,
  input wire logic carrier_detect,
  input wire logic data_set_ready,
  // combined interrupt
  output logic uart_irq
);
  localparam logic [TURN_W-1:0] TURN_LOAD = TURN_W'(TURN_CYCLES);

  line_ctrl_s line_r;
  ctrl_s ctrl_r;
  logic [15:0] baud_div_r;
  logic [8:0] ilp_div_r;
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic [2:0] modem_prev_r;
  logic [15:0] baud_cnt_r;
  logic tick_r;
  logic [8:0] lp_cnt_r;
  logic lp_tick_r;
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wp_r, tx_rp_r;
  logic [4:0] tx_cnt_r;
  rx_entry_s rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] rx_wp_r, rx_rp_r;
  logic [4:0] rx_cnt_r;
  tx_state_e tx_state_r;
  logic [7:0] tx_shift_r;
  logic [2:0] tx_bit_r;
  logic [3:0] tx_tick_r;
  logic tx_par_r, tx_stop_r;
  rx_state_e rx_state_r;
  logic [7:0] rx_data_r;
  logic [2:0] rx_bit_r;
  logic [3:0] rx_tick_r;
  logic rx_par_r;
  logic ir_act_r;
  logic [1:0] ir_pcnt_r;
  logic ir_chk_r;
  logic [8:0] ir_chk_cnt_r;
  logic ir_dec_r;
  logic [3:0] ir_str_r;
  logic [TURN_W-1:0] turn_cnt_r;
  logic ovr_r, ms_flag_r, to_flag_r;
  logic [9:0] to_cnt_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, txd_r, irq_r;

  // apb decode; zero wait states so access ends in one cycle
  logic setup, acc_wr, acc_rd, mapped;
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  always_comb begin
    if (paddr == OFF_DATA) mapped = 1'b1;
    else if (paddr == OFF_STATUS) mapped = 1'b1;
    else if (paddr == OFF_LINE) mapped = 1'b1;
    else if (paddr == OFF_BAUD) mapped = 1'b1;
    else if (paddr == OFF_CTRL) mapped = 1'b1;
    else if (paddr == OFF_ILP) mapped = 1'b1;
    else if (paddr == OFF_INT) mapped = 1'b1;
    else mapped = 1'b0;
  end

  // fifo capacity and levels
  logic [4:0] cap;
  logic tx_full, rx_full, tx_push, rx_pop, tx_pop, rx_push;
  assign cap = line_r.fifo_en ? LVL_FULL : LVL_SINGLE; // RULE8 RULE9
  assign tx_full = tx_cnt_r >= cap;
  assign rx_full = rx_cnt_r >= cap;
  assign tx_push = acc_wr & (paddr == OFF_DATA) & ~tx_full;
  assign rx_pop = acc_rd & (paddr == OFF_DATA) & (rx_cnt_r != 5'h00);

  // wired inputs are ignored in infrared mode
  logic rx_in, ir_raw, rx_ok, tx_ok;
  assign ir_raw = sync2_r[SY_IR];
  assign rx_in = ctrl_r.ir_en ? ir_dec_r : sync2_r[SY_RX]; // RULE17 RULE18
  // half duplex with turnaround in infrared mode
  assign rx_ok = ~ctrl_r.ir_en | ((tx_state_r == T_IDLE) & (turn_cnt_r == '0)); // RULE19 RULE20
  assign tx_ok = ~ctrl_r.ir_en | (rx_state_r == R_IDLE); // RULE19

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r <= LINE_RST;
      ctrl_r <= CTRL_RST;
      baud_div_r <= BAUD_MIN;
      ilp_div_r <= ILP_MIN;
    end else if (acc_wr) begin
      if (paddr == OFF_LINE) line_r <= line_ctrl_s'(pwdata[6:0]);
      else if (paddr == OFF_BAUD) baud_div_r <= pwdata[15:0];
      else if (paddr == OFF_CTRL) ctrl_r <= ctrl_s'(pwdata[6:0]);
      else if (paddr == OFF_ILP) ilp_div_r <= pwdata[8:0];
    end
  end

  // two-flop synchronisers for every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {data_set_ready, carrier_detect, clear_to_send, ir_pulse_in, wired_serial_rx};
      sync2_r <= sync1_r;
    end
  end

  // x16 tick: period is divisor+1 clocks, at least two
  logic [15:0] baud_lim;
  assign baud_lim = (baud_div_r < BAUD_MIN) ? BAUD_MIN : baud_div_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (baud_cnt_r >= baud_lim) begin
      baud_cnt_r <= '0;
      tick_r <= 1'b1; // RULE1 RULE23
    end else begin
      baud_cnt_r <= baud_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // low power tick: period equals the divisor, clamped to two
  logic [8:0] lp_lim;
  assign lp_lim = (ilp_div_r < ILP_MIN) ? ILP_MIN : ilp_div_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_cnt_r <= '0;
      lp_tick_r <= 1'b0;
    end else if (lp_cnt_r >= lp_lim - ILP_ONE) begin
      lp_cnt_r <= '0;
      lp_tick_r <= 1'b1; // RULE21
    end else begin
      lp_cnt_r <= lp_cnt_r + ILP_ONE;
      lp_tick_r <= 1'b0;
    end
  end

  // transmit fifo
  always_ff @(posedge pclk) begin
    if (tx_push) tx_mem[tx_wp_r] <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) tx_wp_r <= tx_wp_r + 1'b1;
      if (tx_pop) tx_rp_r <= tx_rp_r + 1'b1;
      tx_cnt_r <= tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop}; // RULE8
    end
  end

  // transmit framing; frames start on a tick so bit edges line up
  logic [2:0] wlast;
  logic [7:0] wmask;
  logic tx_bit_val;
  assign wlast = WLEN_BASE + {1'b0, line_r.wlen}; // RULE2
  assign wmask = 8'hff >> (2'h3 - line_r.wlen);
  assign tx_pop = (tx_state_r == T_IDLE) & tick_r & ctrl_r.uart_en & (tx_cnt_r != 5'h00) & tx_ok;
  always_comb begin
    case (tx_state_r)
      T_START: tx_bit_val = 1'b0;
      T_DATA: tx_bit_val = tx_shift_r[0];
      T_PAR: tx_bit_val = tx_par_r;
      default: tx_bit_val = 1'b1;
    endcase
  end
  logic tx_bit_end, tx_done;
  assign tx_bit_end = tick_r & (tx_tick_r == BIT_LAST);
  assign tx_done = (tx_state_r == T_STOP) & tx_bit_end & (~line_r.stop2 | tx_stop_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= T_IDLE;
      tx_shift_r <= '0;
      tx_bit_r <= '0;
      tx_tick_r <= '0;
      tx_par_r <= 1'b0;
      tx_stop_r <= 1'b0;
    end else begin
      if (tick_r & (tx_state_r != T_IDLE)) tx_tick_r <= tx_tick_r + 4'h1;
      case (tx_state_r)
        T_IDLE: begin
          if (tx_pop) begin
            tx_state_r <= T_START; // RULE5 RULE24
            tx_shift_r <= tx_mem[tx_rp_r] & wmask;
            tx_par_r <= ^(tx_mem[tx_rp_r] & wmask) ^ ~line_r.even; // RULE3
            tx_tick_r <= '0;
            tx_bit_r <= '0;
            tx_stop_r <= 1'b0;
          end
        end
        T_START: begin
          if (tx_bit_end) tx_state_r <= T_DATA;
        end
        T_DATA: begin
          if (tx_bit_end) begin
            tx_shift_r <= {1'b0, tx_shift_r[7:1]}; // RULE24
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == wlast) tx_state_r <= line_r.par_en ? T_PAR : T_STOP; // RULE3
          end
        end
        T_PAR: begin
          if (tx_bit_end) tx_state_r <= T_STOP;
        end
        T_STOP: begin
          if (tx_done) tx_state_r <= T_IDLE;
          else if (tx_bit_end) tx_stop_r <= 1'b1; // RULE4
        end
        default: tx_state_r <= T_IDLE;
      endcase
    end
  end

  // infrared encoder: one pulse at the start of each zero bit
  logic pulse_tick;
  assign pulse_tick = ctrl_r.ir_lp ? lp_tick_r : tick_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_act_r <= 1'b0;
      ir_pcnt_r <= '0;
    end else if (ctrl_r.ir_en & tick_r & (tx_state_r != T_IDLE) & (tx_tick_r == 4'h0) &
                 ~tx_bit_val) begin
      ir_act_r <= 1'b1; // RULE26
      ir_pcnt_r <= '0;
    end else if (ir_act_r & pulse_tick) begin
      ir_pcnt_r <= ir_pcnt_r + 2'h1;
      if (ir_pcnt_r == PULSE_LAST) ir_act_r <= 1'b0; // RULE22
    end
  end

  // infrared decoder: check low one low power period on, then stretch a bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_chk_r <= 1'b0;
      ir_chk_cnt_r <= '0;
      ir_dec_r <= 1'b1;
      ir_str_r <= '0;
    end else begin
      if (!ir_chk_r) begin
        if (ctrl_r.ir_en & ~ir_raw & (tx_state_r == T_IDLE)) begin
          ir_chk_r <= 1'b1;
          ir_chk_cnt_r <= ILP_ONE;
        end
      end else if (ir_chk_cnt_r >= lp_lim) begin
        ir_chk_r <= 1'b0;
        if (!ir_raw) begin
          ir_dec_r <= 1'b0; // RULE25
          ir_str_r <= '0;
        end
      end else begin
        ir_chk_cnt_r <= ir_chk_cnt_r + ILP_ONE;
      end
      // a glitch shorter than the check never reaches the receiver
      if (!ir_dec_r & tick_r & ~(ir_chk_r & (ir_chk_cnt_r >= lp_lim) & ~ir_raw)) begin
        ir_str_r <= ir_str_r + 4'h1;
        if (ir_str_r == BIT_LAST) ir_dec_r <= 1'b1;
      end
    end
  end

  // infrared turnaround after each transmitted frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) turn_cnt_r <= '0;
    else if (tx_done & ctrl_r.ir_en) turn_cnt_r <= TURN_LOAD; // RULE20
    else if (turn_cnt_r != '0) turn_cnt_r <= turn_cnt_r - 1'b1;
  end

  // receive framing; sample at mid bit
  logic rx_samp, rx_stop_end, rx_brk;
  assign rx_samp = tick_r & (rx_tick_r == BIT_LAST);
  assign rx_stop_end = (rx_state_r == R_STOP) & rx_samp;
  assign rx_brk = (rx_data_r == 8'h00) & ~rx_par_r & ~rx_in; // RULE7
  assign rx_push = rx_stop_end & ~rx_full;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_r <= R_IDLE;
      rx_data_r <= '0;
      rx_bit_r <= '0;
      rx_tick_r <= '0;
      rx_par_r <= 1'b0;
    end else begin
      if (tick_r & (rx_state_r != R_IDLE)) rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_state_r)
        R_IDLE: begin
          if (ctrl_r.uart_en & ~rx_in & rx_ok) begin
            rx_state_r <= R_START;
            rx_tick_r <= '0;
            rx_data_r <= '0;
            rx_bit_r <= '0;
            rx_par_r <= 1'b0;
          end
        end
        R_START: begin
          if (tick_r & (rx_tick_r == HALF_BIT)) begin
            rx_tick_r <= '0;
            rx_state_r <= rx_in ? R_IDLE : R_DATA; // RULE6
          end
        end
        R_DATA: begin
          if (rx_samp) begin
            rx_data_r[rx_bit_r] <= rx_in; // RULE24
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == wlast) rx_state_r <= line_r.par_en ? R_PAR : R_STOP;
          end
        end
        R_PAR: begin
          if (rx_samp) begin
            rx_par_r <= rx_in;
            rx_state_r <= R_STOP;
          end
        end
        R_STOP: begin
          if (rx_samp) rx_state_r <= rx_brk ? R_BRK : R_IDLE;
        end
        R_BRK: begin
          if (rx_in) rx_state_r <= R_IDLE; // wait for the line to mark again
        end
        default: rx_state_r <= R_IDLE;
      endcase
    end
  end

  // receive fifo; entry carries its own error flags
  rx_entry_s rx_new;
  always_comb begin
    rx_new.data = rx_data_r; // RULE5
    rx_new.frm_err = ~rx_in; // RULE11
    rx_new.par_err = line_r.par_en & (^rx_data_r ^ rx_par_r ^ ~line_r.even); // RULE3 RULE11
    rx_new.brk_err = rx_brk; // RULE7 RULE11
  end
  always_ff @(posedge pclk) begin
    if (rx_push) rx_mem[rx_wp_r] <= rx_new;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (rx_push) rx_wp_r <= rx_wp_r + 1'b1;
      if (rx_pop) rx_rp_r <= rx_rp_r + 1'b1;
      rx_cnt_r <= rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop}; // RULE8
    end
  end

  // overrun: the full fifo is left untouched; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovr_r <= 1'b0;
    else if (rx_stop_end & rx_full) ovr_r <= 1'b1; // RULE13
    else if (acc_wr & (paddr == OFF_STATUS) & pwdata[ST_OVR]) ovr_r <= 1'b0;
  end

  // modem change flag, blind in infrared mode; set wins over clear
  logic [2:0] modem_now;
  assign modem_now = sync2_r[SY_DSR:SY_CTS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_prev_r <= '0;
      ms_flag_r <= 1'b0;
    end else begin
      modem_prev_r <= modem_now; // RULE16
      if (~ctrl_r.ir_en & (modem_now != modem_prev_r)) ms_flag_r <= 1'b1; // RULE18
      else if (acc_wr & (paddr == OFF_INT) & pwdata[INT_MS]) ms_flag_r <= 1'b0;
    end
  end

  // receive timeout: thirty-two idle bit times with data waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_r <= '0;
      to_flag_r <= 1'b0;
    end else begin
      if (rx_push | rx_pop | (rx_cnt_r == 5'h00) | (rx_state_r != R_IDLE)) to_cnt_r <= '0;
      else if (tick_r & (to_cnt_r < TIMEOUT_TICKS)) to_cnt_r <= to_cnt_r + 10'h001;
      to_flag_r <= (to_cnt_r >= TIMEOUT_TICKS) & (rx_cnt_r != 5'h00);
    end
  end

  // interrupt sources; stored receive errors do not take part
  logic [INT_N-1:0] int_raw;
  assign int_raw[INT_TX] = line_r.fifo_en ? (tx_cnt_r <= LVL_TRIG) : (tx_cnt_r == 5'h00);
  assign int_raw[INT_RX] = line_r.fifo_en ? (rx_cnt_r >= LVL_TRIG) : (rx_cnt_r != 5'h00); // RULE10
  assign int_raw[INT_TO] = to_flag_r;
  assign int_raw[INT_MS] = ms_flag_r; // RULE12 RULE14
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_r <= 1'b0;
    else irq_r <= |(int_raw & ctrl_r.int_mask); // RULE15
  end

  // wired line: high in infrared mode, low while break is requested
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) txd_r <= 1'b1;
    else if (ctrl_r.ir_en) txd_r <= 1'b1; // RULE18
    else txd_r <= ~line_r.brk & tx_bit_val; // RULE7
  end

  // read data latched in setup, answered in access
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    if (paddr == OFF_DATA) rd_val = {21'h000000, rx_mem[rx_rp_r]};
    else if (paddr == OFF_STATUS) begin
      rd_val[ST_OVR] = ovr_r;
      rd_val[ST_TXFULL] = tx_full;
      rd_val[ST_TXEMPTY] = tx_cnt_r == 5'h00;
      rd_val[ST_RXFULL] = rx_full;
      rd_val[ST_RXEMPTY] = rx_cnt_r == 5'h00;
      rd_val[ST_BUSY] = (tx_state_r != T_IDLE) | (tx_cnt_r != 5'h00);
      rd_val[ST_DSR:ST_CTS] = modem_now; // RULE16
    end
    else if (paddr == OFF_LINE) rd_val = {25'h0000000, line_r};
    else if (paddr == OFF_BAUD) rd_val = {16'h0000, baud_div_r};
    else if (paddr == OFF_CTRL) rd_val = {25'h0000000, ctrl_r};
    else if (paddr == OFF_ILP) rd_val = {23'h000000, ilp_div_r};
    else if (paddr == OFF_INT) rd_val = {24'h000000, int_raw & ctrl_r.int_mask, int_raw};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_val;
        pslverr_r <= ~mapped;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign wired_serial_tx = txd_r;
  assign ir_pulse_out_low = ir_act_r;
  assign uart_irq = irq_r;
endmodule : uart_with_ir_sir_endec

// file: dv/uart_ir_sva.sv
// port-level checks for the apb uart with infrared endec
`timescale 1ns/1ps
module uart_ir_sva import uart_ir_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic wired_serial_tx,
  input wire logic uart_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ir_r, brk_r;
  logic [3:0] mask_r;
  // shadow of mode bits, taken at the completing edge of a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_r <= 1'b0;
      brk_r <= 1'b0;
      mask_r <= 4'h0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == OFF_CTRL) ir_r <= pwdata[1];
      if (paddr == OFF_CTRL) mask_r <= pwdata[6:3];
      if (paddr == OFF_LINE) brk_r <= pwdata[6];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_zero_wait: assert property (s_access |-> pready) else $error("pready low");
  a_unmapped_err: assert property (s_setup ##0 paddr > OFF_INT |=> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (s_setup ##0 paddr <= OFF_INT && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("error on mapped");
  a_rdata_holds: assert property (s_access ##1 !psel |-> $stable(prdata))
    else $error("prdata moved");
  a_reset_exit: assert property ($rose(presetn) |-> !pready && wired_serial_tx
    && !uart_irq ##1 pready) else $error("bad reset exit");
  a_ir_tx_high: assert property (ir_r && $past(ir_r) |-> wired_serial_tx)
    else $error("wired tx moved in ir mode");
  a_break_low: assert property (brk_r && $past(brk_r) && !ir_r |-> !wired_serial_tx)
    else $error("break not sent");
  a_irq_masked: assert property (mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !uart_irq)
    else $error("irq while masked");
endmodule : uart_ir_sva

bind uart_with_ir_sir_endec uart_ir_sva uart_ir_sva_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wired_serial_tx, .uart_irq);

// file: dv/serial_peer.sv
// remote serial device: sends frames and catches frames
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT = 32
) (
  // clock
  input wire logic clk,
  // serial lines
  output logic rx_line,
  input wire logic tx_line
);
  // idle line marks high
  initial rx_line = 1'b1;
  // start bit, n bits lsb first, then one idle bit
  task send(input logic [11:0] bits, input int n);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (BIT) @(posedge clk);
    end
    rx_line <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask : send
  // low glitch shorter than half a bit
  task pulse(input int w);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (w) @(posedge clk);
    rx_line <= 1'b1;
  endtask : pulse
  // mid-bit samples after the start edge
  task catch(output logic [11:0] b, input int n);
    b = 12'h000;
    @(negedge tx_line);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = tx_line;
    end
  endtask : catch
endmodule : serial_peer

// file: dv/uart_with_ir_sir_endec_tb.sv
// self-checking bench for the apb uart with infrared endec
`timescale 1ns/1ps
module uart_with_ir_sir_endec_tb import uart_ir_pkg::*;;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err, uart_irq;
  logic [11:0] paddr, b;
  logic [31:0] pwdata, prdata, q;
  logic wired_serial_rx, wired_serial_tx, ir_pulse_in, ir_pulse_out_low;
  logic clear_to_send, carrier_detect, data_set_ready;
  int miscompares = 0;
  int n_checks = 0;
  int hi;
  logic [11:0] ra [6] = '{OFF_STATUS, OFF_LINE, OFF_BAUD, OFF_CTRL, OFF_ILP, 12'h01c};
  logic [31:0] rv [6] = '{32'h14, 32'h03, 32'h01, 32'h00, 32'h02, 32'h00};
  logic [11:0] fv [3] = '{12'h1d5, 12'h155, 12'h0d5};
  logic [10:0] fe [3] = '{11'h055, 11'h255, 11'h155};
  // 250 mhz
  always #2 pclk = ~pclk;
  uart_with_ir_sir_endec #(.TURN_CYCLES(200)) uart_with_ir_sir_endec_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wired_serial_rx,
    .wired_serial_tx, .ir_pulse_in, .ir_pulse_out_low, .clear_to_send, .carrier_detect,
    .data_set_ready, .uart_irq);
  serial_peer #(.BIT(32)) serial_peer_inst (.clk(pclk), .rx_line(wired_serial_rx),
    .tx_line(wired_serial_tx));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // one apb transfer, result taken at the pready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task test_done;
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ir_pulse_in, clear_to_send, carrier_detect, data_set_ready} = 4'h8;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
      chk(err, i == 5);
    end
    apb(1'b1, OFF_CTRL, 32'h01);
    apb(1'b1, OFF_LINE, 32'h0f);
    fork serial_peer_inst.catch(b, 10); apb(1'b1, OFF_DATA, 32'ha5); join
    chk(b, 12'h2a5);
    // five bits, two stops, second byte right behind
    apb(1'b1, OFF_LINE, 32'h10);
    fork
      serial_peer_inst.catch(b, 7);
      begin apb(1'b1, OFF_DATA, 32'h0); apb(1'b1, OFF_DATA, 32'h0); end
    join
    chk(b, 12'h060);
    repeat (300) @(posedge pclk);
    apb(1'b1, OFF_LINE, 32'h40);
    repeat (3) @(posedge pclk);
    chk(wired_serial_tx, 1'b0);
    // seven bits odd parity; glitch must not start a frame
    apb(1'b1, OFF_LINE, 32'h06);
    serial_peer_inst.pulse(6);
    // long enough for a wrongly accepted frame to reach the fifo
    repeat (400) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q[4], 1'b1);
    for (int i = 0; i < 3; i++) begin
      serial_peer_inst.send(fv[i], 9);
      apb(1'b0, OFF_DATA, 32'h0);
      chk(q[10:0], fe[i]);
    end
    // a low stop bit can pass for a start bit; let that frame land, then drop it
    repeat (400) @(posedge pclk);
    apb(1'b0, OFF_DATA, 32'h0);
    serial_peer_inst.send(12'h000, 9);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(q[10], 1'b1);
    // single entry: second byte overruns, first kept
    apb(1'b1, OFF_LINE, 32'h03);
    serial_peer_inst.send(12'h111, 9);
    serial_peer_inst.send(12'h122, 9);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q[0], 1'b1);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(q[7:0], 8'h11);
    apb(1'b1, OFF_STATUS, 32'h1);
    apb(1'b1, OFF_LINE, 32'h23);
    apb(1'b1, OFF_CTRL, 32'h11);
    for (int i = 0; i < 8; i++) begin
      if (i == 7) chk(uart_irq, 1'b0);
      serial_peer_inst.send(12'h130 + 12'(i), 9);
    end
    repeat (3) @(posedge pclk);
    chk(uart_irq, 1'b1);
    apb(1'b0, OFF_INT, 32'h0);
    chk(q[5], 1'b1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, OFF_DATA, 32'h0);
      chk(q[7:0], 8'h30 + 8'(i));
    end
    clear_to_send <= 1'b1;
    repeat (3) @(posedge pclk); // two sync flops before status sees it
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q[6:4], 3'h5);
    // modem source only; the cts change above has set its flag
    apb(1'b1, OFF_CTRL, 32'h41);
    repeat (3) @(posedge pclk);
    chk(uart_irq, 1'b1);
    // infrared: five zero bits, three x16 ticks of two clocks each
    apb(1'b1, OFF_CTRL, 32'h03);
    apb(1'b1, OFF_LINE, 32'h03);
    hi = 0;
    fork
      apb(1'b1, OFF_DATA, 32'hf0);
      repeat (400) begin @(posedge pclk); hi += int'(ir_pulse_out_low); end
    join
    chk(hi, 30);
    test_done;
  end
endmodule : uart_with_ir_sir_endec_tb
